// ==== design/prm_dbg_decode.sv ====
// Purpose: decode debug pin code into pin ownership
// Assumes: forbidden codes fall back to full debug ownership
// Notes: purely combinational
`timescale 1ns/100ps
module prm_dbg_decode
  import prm_pkg::*;
(
  // configuration
  input wire logic [2:0] cfg,
  input wire logic trace_on,
  // decoded ownership
  output logic [4:0] release_mask,
  output logic forbidden,
  output logic jtag_on,
  output logic swd_on
);
  logic [4:0] base;
  always_comb begin
    forbidden = 1'b0;
    jtag_on = 1'b1;
    swd_on = 1'b1;
    case (cfg)
      DBG_CFG_FULL: base = REL_FULL;
      DBG_CFG_NO_TRST: base = REL_NO_TRST;
      DBG_CFG_SW_ONLY: begin
        base = REL_SW_ONLY;
        jtag_on = 1'b0;
      end
      DBG_CFG_NONE: begin
        base = REL_NONE;
        jtag_on = 1'b0;
        swd_on = 1'b0;
      end
      default: begin
        base = REL_FULL;
        forbidden = 1'b1;
      end
    endcase
    release_mask = base;
    if (trace_on) begin
      release_mask[DBG_TDO] = 1'b0;
    end
  end
endmodule // prm_dbg_decode

// ==== design/prm_pin_remap.sv ====
// Purpose: alternate-function remap and debug pin configuration
// Assumes: pins and peripheral signals synchronous to sys_clk
// Notes: configuration loads on write strobes; routed outputs registered
`timescale 1ns/100ps
module prm_pin_remap
  import prm_pkg::*;
#(
  parameter int EXT_LINES = NUM_EXT_LINES
)
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // first remap configuration word
  input wire logic cfg0_wr,
  input wire logic [2:0] debug_pin_config_in,
  input wire logic trace_async_en_in,
  input wire logic conv0_trigger_source_select_in,
  input wire logic conv1_trigger_source_select_in,
  input wire logic [1:0] timer0_pin_map_select_in,
  input wire logic [1:0] timer1_pin_map_select_in,
  input wire logic [1:0] timer2_pin_map_select_in,
  input wire logic timer3_pin_map_select_in,
  input wire logic timer_ch3_internal_source_select_in,
  // second remap configuration word
  input wire logic cfg1_wr,
  input wire logic timer8_pin_map_select_in,
  // external line source selection
  input wire logic ext_sel_wr,
  input wire logic [EXT_LINES*PORT_SEL_W-1:0] ext_line_source_select_in,
  // pins and peripheral sources
  input wire logic [NUM_PORTS*PINS_PER_PORT-1:0] gpio_in,
  input wire logic adv_timer_trigger_out,
  input wire logic internal_slow_rc_osc,
  // routed signals
  output logic [EXT_LINES-1:0] ext_line,
  output logic conv0_trigger,
  output logic conv1_trigger,
  output logic timer1_ch0_in,
  output logic timer2_ch0_in,
  output logic timer4_ch3_in,
  // timer pin set selections
  output logic [1:0] timer0_pin_map,
  output logic [1:0] timer1_pin_map,
  output logic [1:0] timer2_pin_map,
  output logic timer3_pin_map,
  output logic timer8_pin_map,
  // debug pin ownership
  output logic [4:0] dbg_pin_release,
  output logic [4:0] dbg_pin_pull_up,
  output logic [4:0] dbg_pin_pull_dn,
  output logic debug_cfg_forbidden,
  output logic jtag_enabled,
  output logic swd_enabled,
  output logic trace_pin_owned
);
  function automatic logic pick_pin(input logic [NUM_PORTS*PINS_PER_PORT-1:0] pins,
                                    input logic [PIN_IDX_W-1:0] idx);
    pick_pin = pins[idx];
  endfunction

  // configuration registers
  logic [2:0] debug_pin_config, next_debug_pin_config;
  logic trace_on, next_trace_on;
  logic conv0_sel, next_conv0_sel, conv1_sel, next_conv1_sel;
  logic [1:0] t0_map, next_t0_map, t1_map, next_t1_map, t2_map, next_t2_map;
  logic t3_map, next_t3_map, t8_map, next_t8_map, t4_int, next_t4_int;
  logic [EXT_LINES*PORT_SEL_W-1:0] ext_sel, next_ext_sel;

  always_comb begin
    next_debug_pin_config = debug_pin_config;
    next_trace_on = trace_on;
    next_conv0_sel = conv0_sel;
    next_conv1_sel = conv1_sel;
    next_t0_map = t0_map;
    next_t1_map = t1_map;
    next_t2_map = t2_map;
    next_t3_map = t3_map;
    next_t4_int = t4_int;
    next_t8_map = t8_map;
    next_ext_sel = ext_sel;
    if (cfg0_wr) begin
      next_debug_pin_config = debug_pin_config_in;
      next_trace_on = trace_async_en_in;
      next_conv0_sel = conv0_trigger_source_select_in;
      next_conv1_sel = conv1_trigger_source_select_in;
      next_t0_map = timer0_pin_map_select_in;
      next_t1_map = timer1_pin_map_select_in;
      next_t2_map = timer2_pin_map_select_in;
      next_t3_map = timer3_pin_map_select_in;
      next_t4_int = timer_ch3_internal_source_select_in;
    end
    if (cfg1_wr) begin
      next_t8_map = timer8_pin_map_select_in;
    end
    if (ext_sel_wr) begin
      next_ext_sel = ext_line_source_select_in;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      debug_pin_config <= DBG_CFG_RESET;
      trace_on <= 1'b0;
      conv0_sel <= 1'b0;
      conv1_sel <= 1'b0;
      t0_map <= MAP_NONE;
      t1_map <= MAP_NONE;
      t2_map <= MAP_NONE;
      t3_map <= 1'b0;
      t4_int <= 1'b0;
      t8_map <= 1'b0;
      ext_sel <= '0;
    end else if (clk_en) begin
      debug_pin_config <= next_debug_pin_config;
      trace_on <= next_trace_on;
      conv0_sel <= next_conv0_sel;
      conv1_sel <= next_conv1_sel;
      t0_map <= next_t0_map;
      t1_map <= next_t1_map;
      t2_map <= next_t2_map;
      t3_map <= next_t3_map;
      t4_int <= next_t4_int;
      t8_map <= next_t8_map;
      ext_sel <= next_ext_sel;
    end
  end

  // debug ownership decode
  logic [4:0] dec_release;
  logic dec_forbidden, dec_jtag, dec_swd;
  prm_dbg_decode u_dbg_decode (
    .cfg(debug_pin_config),
    .trace_on(trace_on),
    .release_mask(dec_release),
    .forbidden(dec_forbidden),
    .jtag_on(dec_jtag),
    .swd_on(dec_swd)
  );

  // routing, computed from the current register values
  logic [EXT_LINES-1:0] next_ext_line;
  logic next_conv0_trigger, next_conv1_trigger;
  logic next_timer1_ch0_in, next_timer2_ch0_in, next_timer4_ch3_in;
  logic [4:0] next_pull_up, next_pull_dn;
  logic [PORT_SEL_W-1:0] port_sel;
  always_comb begin
    port_sel = '0;
    // line i from pin i of chosen port
    for (int i = 0; i < EXT_LINES; i++) begin
      port_sel = ext_sel[i*PORT_SEL_W +: PORT_SEL_W];
      if (port_sel < PORT_SEL_W'(NUM_PORTS)) begin
        next_ext_line[i] = pick_pin(gpio_in, PIN_IDX_W'(32'(port_sel) * PINS_PER_PORT + i));
      end else begin
        next_ext_line[i] = 1'b0;
      end
    end
    next_conv0_trigger = conv0_sel ? adv_timer_trigger_out : next_ext_line[EXT_LINE_CONV];
    next_conv1_trigger = conv1_sel ? adv_timer_trigger_out : next_ext_line[EXT_LINE_CONV];
    // shared channel 0 / trigger pin
    case (t1_map)
      MAP_NONE, MAP_PART2: next_timer1_ch0_in = pick_pin(gpio_in, PIN_A0);
      default: next_timer1_ch0_in = pick_pin(gpio_in, PIN_A15);
    endcase
    case (t2_map)
      MAP_NONE: next_timer2_ch0_in = pick_pin(gpio_in, PIN_A6);
      MAP_PART2: next_timer2_ch0_in = pick_pin(gpio_in, PIN_B4);
      MAP_FULL: next_timer2_ch0_in = pick_pin(gpio_in, PIN_C6);
      default: next_timer2_ch0_in = 1'b0;
    endcase
    next_timer4_ch3_in = t4_int ? internal_slow_rc_osc : pick_pin(gpio_in, PIN_A3);
    next_pull_up = DBG_PULL_UP & ~dec_release;
    next_pull_dn = DBG_PULL_DN & ~dec_release;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_line <= '0;
      conv0_trigger <= 1'b0;
      conv1_trigger <= 1'b0;
      timer1_ch0_in <= 1'b0;
      timer2_ch0_in <= 1'b0;
      timer4_ch3_in <= 1'b0;
      timer0_pin_map <= MAP_NONE;
      timer1_pin_map <= MAP_NONE;
      timer2_pin_map <= MAP_NONE;
      timer3_pin_map <= 1'b0;
      timer8_pin_map <= 1'b0;
      dbg_pin_release <= REL_FULL;
      dbg_pin_pull_up <= DBG_PULL_UP;
      dbg_pin_pull_dn <= DBG_PULL_DN;
      debug_cfg_forbidden <= 1'b0;
      jtag_enabled <= 1'b1;
      swd_enabled <= 1'b1;
      trace_pin_owned <= 1'b0;
    end else if (clk_en) begin
      ext_line <= next_ext_line;
      conv0_trigger <= next_conv0_trigger;
      conv1_trigger <= next_conv1_trigger;
      timer1_ch0_in <= next_timer1_ch0_in;
      timer2_ch0_in <= next_timer2_ch0_in;
      timer4_ch3_in <= next_timer4_ch3_in;
      timer0_pin_map <= t0_map;
      timer1_pin_map <= t1_map;
      timer2_pin_map <= t2_map;
      timer3_pin_map <= t3_map;
      timer8_pin_map <= t8_map;
      dbg_pin_release <= dec_release;
      dbg_pin_pull_up <= next_pull_up;
      dbg_pin_pull_dn <= next_pull_dn;
      debug_cfg_forbidden <= dec_forbidden;
      jtag_enabled <= dec_jtag;
      swd_enabled <= dec_swd;
      trace_pin_owned <= trace_on;
    end
  end

  // checks
  sequence s_load0;
    clk_en && cfg0_wr;
  endsequence
  sequence s_settle;
    clk_en ##1 clk_en;
  endsequence

  property p_trig0;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en |=> conv0_trigger == ($past(conv0_sel) ? $past(adv_timer_trigger_out) : $past(next_ext_line[EXT_LINE_CONV]));
  endproperty
  a_trig0: assert property (p_trig0) else $error("conv0 trigger source wrong");

  property p_trig1;
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && conv1_sel) |=> conv1_trigger == $past(adv_timer_trigger_out);
  endproperty
  a_trig1: assert property (p_trig1) else $error("conv1 trigger not timer");

  property p_ext0;
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && ext_sel[PORT_SEL_W-1:0] == '0) |=> ext_line[0] == $past(gpio_in[0]);
  endproperty
  a_ext0: assert property (p_ext0) else $error("ext line 0 source wrong");

  property p_sw_only;
    @(posedge sys_clk) disable iff (!reset_n)
    (s_load0 and debug_pin_config_in == DBG_CFG_SW_ONLY && !trace_async_en_in) ##1 s_settle
      |-> dbg_pin_release == REL_SW_ONLY && !jtag_enabled && swd_enabled;
  endproperty
  a_sw_only: assert property (p_sw_only) else $error("code 010 release wrong");

  property p_trace;
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && trace_on) |=> !dbg_pin_release[DBG_TDO] && trace_pin_owned;
  endproperty
  a_trace: assert property (p_trace) else $error("trace pin released");

  property p_full;
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && debug_pin_config == DBG_CFG_FULL) |=> dbg_pin_release == REL_FULL && dbg_pin_pull_up == DBG_PULL_UP;
  endproperty
  a_full: assert property (p_full) else $error("full debug pins released");

  property p_osc;
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && t4_int) |=> timer4_ch3_in == $past(internal_slow_rc_osc);
  endproperty
  a_osc: assert property (p_osc) else $error("ch3 not on oscillator");

  property p_t8;
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && cfg0_wr && !cfg1_wr) |=> $stable(t8_map);
  endproperty
  a_t8: assert property (p_t8) else $error("timer8 map took first word");

  property p_freeze;
    @(posedge sys_clk) disable iff (!reset_n)
    !clk_en |=> $stable(dbg_pin_release) && $stable(ext_line) && $stable(timer1_pin_map);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule // prm_pin_remap

// ==== design/prm_pkg.sv ====
// Purpose: constants for pin remap and debug pin configuration
// Assumes: five debug pins, five ports of sixteen pins
// Notes: pin release masks use bit order tms, tck, tdi, tdo, trst
// Functional notes
// - each pin selectable among up to four functions
// - software picks source port for each external line
// - three-bit debug code, resets to full debug
// - 001 frees trst, 010 three, 100 all
// - async trace keeps data-out pin on debug
// - reset: serial-wire/JTAG on, trace off
// - converter trigger: line 11 or advanced timer
// - two-bit maps timers 0-2, one-bit timers 3,8
// - timer 8 selector comes from second register
// - timer 4 channel 3: pin or slow oscillator
// - released debug pins act as plain GPIO
package prm_pkg;
  localparam int PINS_PER_PORT = 16;
  localparam int NUM_PORTS = 5;
  localparam int NUM_EXT_LINES = 16;
  localparam int PORT_SEL_W = 3;
  localparam int PIN_IDX_W = 7;
  localparam int DBG_PINS = 5;
  // debug pin positions in the release masks
  localparam int DBG_TMS = 0;
  localparam int DBG_TCK = 1;
  localparam int DBG_TDI = 2;
  localparam int DBG_TDO = 3;
  localparam int DBG_TRST = 4;
  localparam int EXT_LINE_CONV = 11;
  // debug configuration codes
  localparam logic [2:0] DBG_CFG_FULL = 3'h0;
  localparam logic [2:0] DBG_CFG_NO_TRST = 3'h1;
  localparam logic [2:0] DBG_CFG_SW_ONLY = 3'h2;
  localparam logic [2:0] DBG_CFG_NONE = 3'h4;
  localparam logic [2:0] DBG_CFG_RESET = DBG_CFG_FULL;
  // pins handed to general-purpose use per code
  localparam logic [4:0] REL_FULL = 5'h00;
  localparam logic [4:0] REL_NO_TRST = 5'h10;
  localparam logic [4:0] REL_SW_ONLY = 5'h1c;
  localparam logic [4:0] REL_NONE = 5'h1f;
  // pull setting of debug-owned pins
  localparam logic [4:0] DBG_PULL_UP = 5'h15;
  localparam logic [4:0] DBG_PULL_DN = 5'h02;
  // timer map selector codes
  localparam logic [1:0] MAP_NONE = 2'h0;
  localparam logic [1:0] MAP_PART1 = 2'h1;
  localparam logic [1:0] MAP_PART2 = 2'h2;
  localparam logic [1:0] MAP_FULL = 2'h3;
  // pin indices in the flat pin vector: port * 16 + pin
  localparam logic [6:0] PIN_A0 = 7'h00;
  localparam logic [6:0] PIN_A3 = 7'h03;
  localparam logic [6:0] PIN_A6 = 7'h06;
  localparam logic [6:0] PIN_A15 = 7'h0f;
  localparam logic [6:0] PIN_B4 = 7'h14;
  localparam logic [6:0] PIN_C6 = 7'h26;
endpackage

// ==== sim/prm_periph_model.sv ====
// Purpose: pads, advanced timer trigger and slow oscillator around the remap block
// Assumes: pad levels and trigger level come from the bench
// Notes: oscillator toggles every clock so a stale or frozen sample shows
`timescale 1ns/100ps
module prm_periph_model
  import prm_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // bench control
  input wire logic [NUM_PORTS*PINS_PER_PORT-1:0] pad_level,
  input wire logic timer_trig,
  // toward the remap block
  output logic [NUM_PORTS*PINS_PER_PORT-1:0] gpio_in,
  output logic adv_timer_trigger_out,
  output logic internal_slow_rc_osc
);
  // input buffers pass pad levels straight through
  assign gpio_in = pad_level;
  assign adv_timer_trigger_out = timer_trig;
  // stand-in for the slow oscillator
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      internal_slow_rc_osc <= 1'b0;
    end else begin
      internal_slow_rc_osc <= ~internal_slow_rc_osc;
    end
  end
endmodule // prm_periph_model

// ==== sim/prm_tb.sv ====
// Purpose: self-checking bench for pin remap and debug pin ownership
// Assumes: config outputs settle one enabled edge after the strobe edge
// Notes: inputs change on the falling edge only
`timescale 1ns/100ps
module testbench;
  import prm_pkg::*;
  logic sys_clk, reset_n, clk_en, cfg0_wr, cfg1_wr, ext_sel_wr, trace_async_en_in, timer_trig;
  logic conv0_trigger_source_select_in, conv1_trigger_source_select_in, timer3_pin_map_select_in;
  logic timer_ch3_internal_source_select_in, timer8_pin_map_select_in;
  logic [2:0] debug_pin_config_in;
  logic [1:0] timer0_pin_map_select_in, timer1_pin_map_select_in, timer2_pin_map_select_in;
  logic [47:0] ext_line_source_select_in;
  logic [79:0] pad_level, gpio_in, base;
  logic adv_timer_trigger_out, internal_slow_rc_osc;
  logic [15:0] ext_line, exp_lines;
  logic conv0_trigger, conv1_trigger, timer1_ch0_in, timer2_ch0_in, timer4_ch3_in, e11, exp_t2;
  logic [1:0] timer0_pin_map, timer1_pin_map, timer2_pin_map;
  logic timer3_pin_map, timer8_pin_map, debug_cfg_forbidden, jtag_enabled, swd_enabled, trace_pin_owned;
  logic [4:0] dbg_pin_release, dbg_pin_pull_up, dbg_pin_pull_dn, exp_rel;
  int num_errors = 0;
  int check_count = 0;

  prm_pin_remap uut (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .cfg0_wr(cfg0_wr), .debug_pin_config_in(debug_pin_config_in), .trace_async_en_in(trace_async_en_in),
    .conv0_trigger_source_select_in(conv0_trigger_source_select_in),
    .conv1_trigger_source_select_in(conv1_trigger_source_select_in),
    .timer0_pin_map_select_in(timer0_pin_map_select_in), .timer1_pin_map_select_in(timer1_pin_map_select_in),
    .timer2_pin_map_select_in(timer2_pin_map_select_in), .timer3_pin_map_select_in(timer3_pin_map_select_in),
    .timer_ch3_internal_source_select_in(timer_ch3_internal_source_select_in),
    .cfg1_wr(cfg1_wr), .timer8_pin_map_select_in(timer8_pin_map_select_in),
    .ext_sel_wr(ext_sel_wr), .ext_line_source_select_in(ext_line_source_select_in),
    .gpio_in(gpio_in), .adv_timer_trigger_out(adv_timer_trigger_out),
    .internal_slow_rc_osc(internal_slow_rc_osc),
    .ext_line(ext_line), .conv0_trigger(conv0_trigger), .conv1_trigger(conv1_trigger),
    .timer1_ch0_in(timer1_ch0_in), .timer2_ch0_in(timer2_ch0_in), .timer4_ch3_in(timer4_ch3_in),
    .timer0_pin_map(timer0_pin_map), .timer1_pin_map(timer1_pin_map), .timer2_pin_map(timer2_pin_map),
    .timer3_pin_map(timer3_pin_map), .timer8_pin_map(timer8_pin_map),
    .dbg_pin_release(dbg_pin_release), .dbg_pin_pull_up(dbg_pin_pull_up), .dbg_pin_pull_dn(dbg_pin_pull_dn),
    .debug_cfg_forbidden(debug_cfg_forbidden), .jtag_enabled(jtag_enabled), .swd_enabled(swd_enabled),
    .trace_pin_owned(trace_pin_owned)
  );
  prm_periph_model partner (
    .sys_clk(sys_clk), .reset_n(reset_n), .pad_level(pad_level), .timer_trig(timer_trig),
    .gpio_in(gpio_in), .adv_timer_trigger_out(adv_timer_trigger_out),
    .internal_slow_rc_osc(internal_slow_rc_osc)
  );

  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobe one group, return once its outputs have settled
  task automatic load(input int which);
    if (which == 0) cfg0_wr = 1'b1;
    else if (which == 1) cfg1_wr = 1'b1;
    else ext_sel_wr = 1'b1;
    @(negedge sys_clk);
    {cfg0_wr, cfg1_wr, ext_sel_wr} = 3'h0;
    @(negedge sys_clk);
  endtask

  function automatic logic [15:0] lines_exp();
    logic [15:0] r;
    logic [2:0] s;
    for (int i = 0; i < 16; i++) begin
      s = ext_line_source_select_in[3*i +: 3];
      r[i] = (s < 3'h5) ? pad_level[s*16+i] : 1'b0;
    end
    return r;
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    #100000;
    num_errors++;
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    {cfg0_wr, cfg1_wr, ext_sel_wr, trace_async_en_in, timer_trig, timer8_pin_map_select_in} = '0;
    {conv0_trigger_source_select_in, conv1_trigger_source_select_in, timer3_pin_map_select_in} = '0;
    timer_ch3_internal_source_select_in = 1'b0;
    {debug_pin_config_in, timer0_pin_map_select_in, timer1_pin_map_select_in, timer2_pin_map_select_in} = '0;
    ext_line_source_select_in = '0;
    base = 80'h3c3c_5a5a_1c40_00a2_0049;
    pad_level = base;
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    check(dbg_pin_release, 5'h00);
    check(dbg_pin_pull_up, 5'h15);
    check(dbg_pin_pull_dn, 5'h02);
    check({jtag_enabled, swd_enabled, trace_pin_owned, debug_cfg_forbidden}, 4'hc);
    check({timer0_pin_map, timer1_pin_map, timer2_pin_map, timer3_pin_map, timer8_pin_map}, 8'h00);
    // every code, legal and forbidden
    for (int c = 0; c < 8; c++) begin
      debug_pin_config_in = 3'(c);
      load(0);
      case (c)
        1: exp_rel = REL_NO_TRST;
        2: exp_rel = REL_SW_ONLY;
        4: exp_rel = REL_NONE;
        default: exp_rel = REL_FULL;
      endcase
      check(dbg_pin_release, exp_rel);
      check(dbg_pin_pull_up, DBG_PULL_UP & ~exp_rel);
      check(dbg_pin_pull_dn, DBG_PULL_DN & ~exp_rel);
      check({jtag_enabled, swd_enabled, debug_cfg_forbidden}, {c != 2 && c != 4, c != 4, !(c inside {0, 1, 2, 4})});
      // debugger keeps tms and tck for its select sequence
      if (c != 4) check(dbg_pin_release[DBG_TCK:DBG_TMS], 2'h0);
    end
    debug_pin_config_in = 3'h4;
    trace_async_en_in = 1'b1;
    load(0);
    check(dbg_pin_release, 5'h17);
    check(trace_pin_owned, 1'b1);
    // strobe while disabled must not load
    clk_en = 1'b0;
    debug_pin_config_in = 3'h0;
    trace_async_en_in = 1'b0;
    load(0);
    clk_en = 1'b1;
    @(negedge sys_clk);
    check(dbg_pin_release, 5'h17);
    load(0);
    check(dbg_pin_release, 5'h00);
    for (int i = 0; i < 16; i++) ext_line_source_select_in[3*i +: 3] = 3'(i % 8);
    load(2);
    check(ext_line, lines_exp());
    pad_level = ~base;
    @(negedge sys_clk);
    check(ext_line, lines_exp());
    exp_lines = lines_exp();
    e11 = exp_lines[11];
    timer_trig = ~e11;
    for (int k = 0; k < 2; k++) begin
      conv0_trigger_source_select_in = k[0];
      conv1_trigger_source_select_in = ~k[0];
      load(0);
      check({conv0_trigger, conv1_trigger}, k ? {~e11, e11} : {e11, ~e11});
    end
    // timer pin sets over both pad polarities
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        pad_level = p ? ~base : base;
        timer0_pin_map_select_in = 2'(m);
        timer1_pin_map_select_in = 2'(m);
        timer2_pin_map_select_in = 2'(3 - m);
        timer3_pin_map_select_in = m[0];
        load(0);
        check({timer0_pin_map, timer1_pin_map, timer2_pin_map, timer3_pin_map}, {2'(m), 2'(m), 2'(3 - m), m[0]});
        // shared pin used as channel 0 only
        check(timer1_ch0_in, m[0] ? pad_level[15] : pad_level[0]);
        case (timer2_pin_map_select_in)
          2'h0: exp_t2 = pad_level[6];
          2'h2: exp_t2 = pad_level[20];
          2'h3: exp_t2 = pad_level[38];
          default: exp_t2 = 1'b0;
        endcase
        check(timer2_ch0_in, exp_t2);
        check(timer8_pin_map, 1'b0);
      end
    end
    timer8_pin_map_select_in = 1'b1;
    load(1);
    check(timer8_pin_map, 1'b1);
    // last map load: timers 0 and 1 at 11, timer 2 at 00, timer 3 at 1
    check({timer0_pin_map, timer1_pin_map, timer2_pin_map, timer3_pin_map}, 7'h79);
    load(0);
    check(timer4_ch3_in, pad_level[3]);
    timer_ch3_internal_source_select_in = 1'b1;
    load(0);
    for (int n = 0; n < 3; n++) begin
      check(timer4_ch3_in, !internal_slow_rc_osc);
      @(negedge sys_clk);
    end
    complete_run();
  end
endmodule // testbench
